// file: design/ccs_defs.svh
// Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes a 100 MHz ref_clk; register index equals the 10-bit register address.
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// Register addresses
`define CCS_ADDR_CTRL       10'h000
`define CCS_ADDR_RAW        10'h00B
`define CCS_ADDR_SEQ_CFG    10'h001
`define CCS_ADDR_STAGE_BASE 10'h080
`define CCS_STAGE_STRIDE    8
`define CCS_ADDR_RES_BASE   10'h0E0

// Control and sequence register fields
`define CCS_MODE_LSB  0
`define CCS_DLY_LSB   2
`define CCS_DEC_LSB   8
`define CCS_SEQ_LSB   0
`define CCS_SKIP_LSB  4

// Reset values
`define CCS_CTRL_RST  16'h0000
`define CCS_SEQCFG_RST 16'h0000

// Timing: modulator 240 kHz at 100 MHz
`define CCS_CLK_HZ      100000000
`define CCS_MOD_HZ      240000
`define CCS_MOD_DIV     (`CCS_CLK_HZ / `CCS_MOD_HZ)
`define CCS_LP_STEP_MS  100
`define CCS_LP_STEP_CYC (`CCS_LP_STEP_MS * (`CCS_CLK_HZ / 1000))

`define CCS_N_INPUTS 14
`define CCS_N_STAGES 12

`endif

// file: design/ccs_pkg.sv
// Types shared by the capacitance conversion sequencer files.
// Assumes ccs_defs.svh for sizes and offsets.
`include "ccs_defs.svh"
package ccs_pkg;

  typedef enum logic [1:0] {
    CCS_ROUTE_FLOAT = 2'b00,
    CCS_ROUTE_NEG   = 2'b01,
    CCS_ROUTE_POS   = 2'b10,
    CCS_ROUTE_SHLD  = 2'b11
  } ccs_route_e;

  typedef enum logic [1:0] {
    CCS_ST_IDLE  = 2'b00,
    CCS_ST_CONV  = 2'b01,
    CCS_ST_SLEEP = 2'b10
  } ccs_state_e;

  // Host register access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [9:0]  addr;
    logic [15:0] wdata;
  } ccs_bus_s;

  // Per-stage front-end configuration as seen by the analog side
  typedef struct packed {
    logic [27:0] route;
    logic [6:0]  pos_off;
    logic [6:0]  neg_off;
    logic        pos_to_neg;
    logic        neg_to_pos;
  } ccs_afe_s;

endpackage

// file: design/ccs_decimator.sv
// Averaging decimator: sums modulator bits and emits a 16-bit average.
// Assumes one mod_bit per mod_tick and a start pulse at the beginning of a stage.
`timescale 1ns/1ps
module ccs_decimator
  import ccs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        mod_tick,
  input  wire logic        mod_bit,
  input  wire logic [1:0]  dec_sel,
  output logic [15:0]      result,
  output logic             done
);

  typedef struct packed {
    logic        busy;
    logic [8:0]  cnt;
    logic [8:0]  ones;
    logic [15:0] result;
    logic        done;
  } ccs_dec_s;

  ccs_dec_s st_reg;
  ccs_dec_s st_next;

  // Samples per result: 00 -> 256, 01 -> 128, 10/11 -> 64
  function automatic logic [8:0] ccs_dec_len(input logic [1:0] sel);
    unique case (sel)
      2'b00:   ccs_dec_len = 9'h100;
      2'b01:   ccs_dec_len = 9'h080;
      default: ccs_dec_len = 9'h040;
    endcase
  endfunction

  // Scale the count of ones to full 16-bit range; shift keeps it a true average
  function automatic logic [15:0] ccs_scale(input logic [8:0] ones, input logic [1:0] sel);
    logic [24:0] wide;
    wide = {ones, 16'h0000};
    unique case (sel)
      2'b00:   ccs_scale = wide[23:8];
      2'b01:   ccs_scale = wide[22:7];
      default: ccs_scale = wide[21:6];
    endcase
    if (ones == ccs_dec_len(sel)) begin
      ccs_scale = 16'hFFFF;
    end
  endfunction

  // Count samples equal to the decimation ratio, then output the average
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (start) begin
      st_next.busy = 1'b1;
      st_next.cnt  = 9'h000;
      st_next.ones = 9'h000;
    end else if (st_reg.busy && mod_tick) begin
      st_next.cnt  = st_reg.cnt + 9'h001;
      st_next.ones = st_reg.ones + {8'h00, mod_bit};
      if (st_reg.cnt + 9'h001 == ccs_dec_len(dec_sel)) begin
        st_next.busy   = 1'b0;
        st_next.result = ccs_scale(st_reg.ones + {8'h00, mod_bit}, dec_sel);
        st_next.done   = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign result = st_reg.result;
  assign done   = st_reg.done;

endmodule

// file: design/ccs_skip_gate.sv
// Fast FIFO sample selector: marks which results feed proximity detection.
// Assumes result_done pulses once per finished stage result.
`timescale 1ns/1ps
module ccs_skip_gate
  import ccs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        seq_start,
  input  wire logic        result_done,
  input  wire logic [3:0]  skip_cnt,
  output logic             ff_push
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       push;
  } ccs_skip_s;

  ccs_skip_s st_reg;
  ccs_skip_s st_next;

  // Keep one result, then skip the next skip_cnt results
  always_comb begin
    st_next = st_reg;
    st_next.push = 1'b0;
    if (seq_start) begin
      st_next.cnt = 4'h0;
    end else if (result_done) begin
      if (st_reg.cnt == 4'h0) begin
        st_next.push = 1'b1;
        st_next.cnt  = skip_cnt;
      end else begin
        st_next.cnt = st_reg.cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ff_push = st_reg.push;

endmodule

// file: design/ccs_sequencer.sv
// Capacitance conversion sequencer: registers, stage sequencing, modulator
// pacing, low-power wake timing and result registers.
// Assumes a synchronous host register port and a 1-bit modulator stream input.
//
// How it works
// - Each stage routes each of 14 inputs: floating, negative, positive or shield.
// - Results are 16 bits from a modulator paced at 240 kHz.
// - Decimation code sits in control bits 9 and 8.
// - Result averages 256, 128 or 64 samples for codes 00, 01, 1x.
// - Result rates follow: 937.5 Hz, 1.875 kHz, 3.75 kHz.
// - Separate 7-bit positive and negative offsets, each steerable to either input.
// - Up to 12 stages, each with its own configuration.
// - Sequence starts at stage zero and ends at the programmed last index.
// - Last-stage register holds final index, so 5 runs six stages.
// - Differential pair reports at most one button, neither if both pressed.
// - Sequence time follows last index and decimation together; skip count does not change it.
// - Skip count decides which results skip the fast FIFO.
// - Low-power delay code sits in bits 3 and 2 of register 0.
// - Delay codes give 100, 200, 300 or 400 ms.
// - Low-power interval is sequence time plus the selected delay.
// - Raw 16-bit result readable at address 0x00B.
// - Per-stage results sit in a readable third-bank area.
// - Mode bits 1:0: 00 full, 10 low power, 01/11 shutdown; reset 00.
`timescale 1ns/1ps
`include "ccs_defs.svh"
module ccs_sequencer
  import ccs_pkg::*;
#(
  parameter int unsigned LP_STEP_CYC = `CCS_LP_STEP_CYC
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [9:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  input  wire logic        mod_bit,
  input  wire logic        btn_a_touch,
  input  wire logic        btn_b_touch,
  output ccs_afe_s         afe_cfg,
  output logic             mod_sample,
  output logic [3:0]       stage_idx,
  output logic             converting,
  output logic             ff_push,
  output logic             btn_a_active,
  output logic             btn_b_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map; every register is one 16-bit word
  //   0x000        control: mode [1:0], low-power delay [3:2], decimation [9:8]
  //   0x001        sequence: last stage index [3:0], fast FIFO skip count [7:4]
  //   0x00B        raw converter result, read only
  //   0x080 + 8*s  routing of sense inputs 0 to 6 of stage s, two bits per input
  //   0x081 + 8*s  routing of sense inputs 7 to 13 of stage s
  //   0x082 + 8*s  positive offset [6:0], its steer [7], negative offset [14:8],
  //                its steer [15]
  //   0x0E0 + s    result of stage s, read only
  // Route codes: 00 floating, 01 negative input, 10 positive input, 11 shield.
  // Unmapped reads return zero and unmapped writes are dropped, so a host that
  // probes the map cannot disturb a running sequence.
  // A last-stage index above 11 is clamped and the sequence runs all 12 stages.
  // Control writes act at the next edge: a new decimation code changes the
  // length of the stage already running, so reprogram between sequences or
  // from shutdown.
  // Mode writes that select shutdown abort the stage in progress; its partial
  // sum is thrown away when the next stage starts.
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ccs_state_e  state;
    logic        conv;
    logic [15:0] ctrl;
    logic [15:0] seq_cfg;
    logic [3:0]  stage;
    logic [8:0]  mod_cnt;
    logic        mod_tick;
    logic        dec_start;
    logic        seq_start;
    logic [31:0] wait_cnt;
    logic [15:0] raw;
    logic [15:0] rdata;
    ccs_afe_s    afe;
    logic        btn_a;
    logic        btn_b;
  } ccs_top_s;

  // Per-stage config words: 2 route words, 1 offset word; stage results
  logic [15:0] stage_cfg [0:`CCS_N_STAGES-1][0:2];
  logic [15:0] stage_res [0:`CCS_N_STAGES-1];

  ccs_top_s    st_reg;
  ccs_top_s    st_next;
  logic [15:0] dec_result;
  logic        dec_done;
  logic [5:0]  cfg_hit;

  // Decodes a stage register address into {stage, word}; all ones when unmapped
  function automatic logic [5:0] ccs_cfg_hit(input logic [9:0] a);
    logic [9:0] off;
    off = a - `CCS_ADDR_STAGE_BASE;
    ccs_cfg_hit = 6'h3F;
    // Word 3 of stage 15 can never be valid, which frees the all-ones code
    if (a >= `CCS_ADDR_STAGE_BASE && off[9:3] < 7'(`CCS_N_STAGES) && off[2:0] < 3'h3) begin
      ccs_cfg_hit = {off[6:3], off[1:0]};
    end
  endfunction

  // One decode shared by the read mux and the array write port
  assign cfg_hit = ccs_cfg_hit(reg_addr);

  // Gather one stage's front-end view: 28 route bits, offsets and steering
  function automatic ccs_afe_s ccs_afe_of(input logic [15:0] w0,
                                          input logic [15:0] w1,
                                          input logic [15:0] w2);
    ccs_afe_s a;
    a.route      = {w1[13:0], w0[13:0]};
    a.pos_off    = w2[6:0];
    a.pos_to_neg = w2[7];
    a.neg_off    = w2[14:8];
    a.neg_to_pos = w2[15];
    ccs_afe_of = a;
  endfunction

  // Delay steps: 00..11 -> 1..4 steps of 100 ms
  function automatic logic [31:0] ccs_lp_wait(input logic [1:0] sel);
    ccs_lp_wait = 32'(LP_STEP_CYC) * ({30'h0, sel} + 32'h1);
  endfunction

  // Decimator counts paced modulator ticks; a start pulse drops any partial sum
  ccs_decimator u_dec (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (st_reg.dec_start),
    .mod_tick (st_reg.mod_tick),
    .mod_bit  (mod_bit),
    .dec_sel  (st_reg.ctrl[`CCS_DEC_LSB +: 2]),
    .result   (dec_result),
    .done     (dec_done)
  );

  // Skip gate sees every stage result and restarts its count with each sequence
  ccs_skip_gate u_skip (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .seq_start   (st_reg.seq_start),
    .result_done (dec_done),
    .skip_cnt    (st_reg.seq_cfg[`CCS_SKIP_LSB +: 4]),
    .ff_push     (ff_push)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: register writes, pacing, stage sequencing
  always_comb begin
    logic [1:0] mode;
    logic [3:0] last;
    st_next = st_reg;
    mode = st_reg.ctrl[`CCS_MODE_LSB +: 2];
    last = st_reg.seq_cfg[`CCS_SEQ_LSB +: 4];
    // An index past the last stage would address no configuration at all
    if (last > 4'(`CCS_N_STAGES - 1)) begin
      last = 4'(`CCS_N_STAGES - 1);
    end
    st_next.dec_start = 1'b0;
    st_next.seq_start = 1'b0;
    st_next.mod_tick  = 1'b0;

    // Host writes
    // Only control and sequence words live here; stage words go to the array
    if (reg_wr) begin
      if (reg_addr == `CCS_ADDR_CTRL) begin
        st_next.ctrl = reg_wdata;
      end else if (reg_addr == `CCS_ADDR_SEQ_CFG) begin
        st_next.seq_cfg = reg_wdata;
      end
    end

    // Host reads, registered one cycle later
    // reg_rdata holds its value until the next read strobe
    if (reg_rd) begin
      st_next.rdata = 16'h0000;
      if (reg_addr == `CCS_ADDR_CTRL) begin
        st_next.rdata = st_reg.ctrl;
      end else if (reg_addr == `CCS_ADDR_SEQ_CFG) begin
        st_next.rdata = st_reg.seq_cfg;
      end else if (reg_addr == `CCS_ADDR_RAW) begin
        st_next.rdata = st_reg.raw;
      end else if (reg_addr >= `CCS_ADDR_RES_BASE &&
                   reg_addr < `CCS_ADDR_RES_BASE + 10'(`CCS_N_STAGES)) begin
        st_next.rdata = stage_res[4'(reg_addr - `CCS_ADDR_RES_BASE)];
      end else if (cfg_hit != 6'h3F) begin
        st_next.rdata = stage_cfg[cfg_hit[5:2]][cfg_hit[1:0]];
      end
    end

    // Modulator pacing at 240 kHz during conversions
    // The divider truncates, so ticks come every 416 cycles, slightly fast
    if (st_reg.state == CCS_ST_CONV) begin
      if (st_reg.mod_cnt == 9'(`CCS_MOD_DIV - 1)) begin
        st_next.mod_cnt  = 9'h000;
        st_next.mod_tick = 1'b1;
      end else begin
        st_next.mod_cnt = st_reg.mod_cnt + 9'h001;
      end
    end else begin
      st_next.mod_cnt = 9'h000;
    end

    // Sequencing; rate emerges from ratio, stage count and delay
    //   IDLE  shutdown or just out of reset; nothing is paced
    //   CONV  one stage at a time, each decimator result moves to the next stage
    //   SLEEP low power only; counts the wake delay, then restarts at stage zero
    // A mode change is seen at any edge, so shutdown never waits for a stage end
    unique case (st_reg.state)
      CCS_ST_IDLE: begin
        if (mode == 2'b00 || mode == 2'b10) begin
          st_next.state     = CCS_ST_CONV;
          st_next.stage     = 4'h0;
          st_next.seq_start = 1'b1;
          st_next.dec_start = 1'b1;
        end
      end
      CCS_ST_CONV: begin
        if (mode[0]) begin
          st_next.state = CCS_ST_IDLE;
        end else if (dec_done) begin
          if (st_reg.stage >= last) begin
            st_next.stage = 4'h0;
            if (mode == 2'b10) begin
              st_next.state    = CCS_ST_SLEEP;
              st_next.wait_cnt = ccs_lp_wait(st_reg.ctrl[`CCS_DLY_LSB +: 2]);
            end else begin
              st_next.seq_start = 1'b1;
              st_next.dec_start = 1'b1;
            end
          end else begin
            st_next.stage     = st_reg.stage + 4'h1;
            st_next.dec_start = 1'b1;
          end
        end
      end
      CCS_ST_SLEEP: begin
        if (mode != 2'b10) begin
          st_next.state = CCS_ST_IDLE;
        end else if (st_reg.wait_cnt <= 32'h1) begin
          st_next.state     = CCS_ST_CONV;
          st_next.seq_start = 1'b1;
          st_next.dec_start = 1'b1;
        end else begin
          st_next.wait_cnt = st_reg.wait_cnt - 32'h1;
        end
      end
      default: st_next.state = CCS_ST_IDLE;
    endcase

    // Completed result only; host never sees a partial value
    if (dec_done && st_reg.state == CCS_ST_CONV) begin
      st_next.raw = dec_result;
      // Differential pair: exclusive, both pressed reports neither
      st_next.btn_a = btn_a_touch && !btn_b_touch;
      st_next.btn_b = btn_b_touch && !btn_a_touch;
    end

    st_next.afe = ccs_afe_of(stage_cfg[st_next.stage][0], stage_cfg[st_next.stage][1],
                             stage_cfg[st_next.stage][2]);

    // Registered so the converting pin is a clean flip-flop output
    st_next.conv = (st_next.state == CCS_ST_CONV);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered state
  // Reset selects full power, so conversions begin at the first edge after it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= '0;
      st_reg.ctrl  <= `CCS_CTRL_RST;
      st_reg.seq_cfg <= `CCS_SEQCFG_RST;
      st_reg.state <= CCS_ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Stage configuration and stage result storage; memories take no reset
  // The host must program every stage it uses before selecting a running mode
  always_ff @(posedge ref_clk) begin
    if (reg_wr && cfg_hit != 6'h3F) begin
      stage_cfg[cfg_hit[5:2]][cfg_hit[1:0]] <= reg_wdata;
    end
    if (dec_done && st_reg.state == CCS_ST_CONV) begin
      stage_res[st_reg.stage] <= dec_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  // converting has its own flop so no decode glitch reaches the pin
  assign reg_rdata    = st_reg.rdata;
  assign afe_cfg      = st_reg.afe;
  assign mod_sample   = st_reg.mod_tick;
  assign stage_idx    = st_reg.stage;
  assign converting   = st_reg.conv;
  assign btn_a_active = st_reg.btn_a;
  assign btn_b_active = st_reg.btn_b;

endmodule

// file: tb/ccs_sequencer_asserts.sv
// Port checker for the conversion sequencer.
// Assumes host writes land at the edge where reg_wr is high.
`timescale 1ns/1ps
module ccs_chk
  import ccs_pkg::*;
#(
  parameter int unsigned LP_STEP_CYC = 100
)
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic [9:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        mod_sample,
  input wire logic [3:0]  stage_idx,
  input wire logic        converting,
  input wire logic        btn_a_active,
  input wire logic        btn_b_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] ctl_reg;
  logic [3:0]  last_reg;
  logic [3:0]  stg_reg;
  logic [9:0]  gap_reg;
  logic [8:0]  cnt_reg;
  logic [8:0]  ratio;
  logic        restart;
  assign ratio   = ctl_reg[9] ? 9'd64 : (ctl_reg[8] ? 9'd128 : 9'd256);
  assign restart = !converting || (stage_idx != stg_reg);
  //////////////////////////////////////////////////
  // Shadows of host writes; tick counts restart per stage so gaps never span two
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg  <= 16'h0000;
      last_reg <= 4'h0;
      stg_reg  <= 4'h0;
      gap_reg  <= 10'h3FF;
      cnt_reg  <= 9'h000;
    end else begin
      if (reg_wr && reg_addr == 10'h000) ctl_reg <= reg_wdata;
      if (reg_wr && reg_addr == 10'h001) last_reg <= reg_wdata[3:0];
      stg_reg <= stage_idx;
      cnt_reg <= restart ? {8'h00, mod_sample} : cnt_reg + {8'h00, mod_sample};
      if (restart) gap_reg <= 10'h3FF;
      else if (mod_sample) gap_reg <= 10'h000;
      else if (gap_reg != 10'h3FF) gap_reg <= gap_reg + 10'h001;
    end
  end
  //////////////////////////////////////////////////
  chk_tick_gap: assert property (mod_sample && gap_reg != 10'h3FF |->
    gap_reg inside {[10'd415:10'd416]}) else $error("modulator tick spacing off");
  chk_tick_alive: assert property (gap_reg != 10'h3FF |-> gap_reg < 10'd420)
    else $error("modulator tick missing");
  chk_stage_ratio: assert property (stage_idx != stg_reg && converting
    && $past(converting) |-> cnt_reg == ratio) else $error("samples per stage off");
  chk_stage_step: assert property (stage_idx != stg_reg |->
    stage_idx == stg_reg + 4'h1 || stage_idx == 4'h0) else $error("stage order off");
  chk_last_stage: assert property (stage_idx <= last_reg && stage_idx <= 4'hB)
    else $error("stage beyond last");
  chk_btn_pair: assert property (!(btn_a_active && btn_b_active))
    else $error("both buttons active");
  chk_shutdown_stop: assert property (ctl_reg[0] [*3] |-> !converting)
    else $error("converting in shutdown");
  chk_full_run: assert property ((ctl_reg[1:0] == 2'b00) [*3] |-> converting)
    else $error("full power stopped");
endmodule

bind ccs_sequencer ccs_chk #(.LP_STEP_CYC(LP_STEP_CYC)) i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .mod_sample(mod_sample), .stage_idx(stage_idx),
  .converting(converting), .btn_a_active(btn_a_active), .btn_b_active(btn_b_active));

// file: tb/ccs_electrodes.sv
// Behavioural sensor electrodes: modulator stream and touch levels.
// Assumes input 0 routing decides the stream density.
`timescale 1ns/1ps
module ccs_electrodes
  import ccs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire ccs_afe_s   afe_cfg,
  input  wire logic       mod_sample,
  input  wire logic [1:0] press,
  output logic            mod_bit,
  output logic            btn_a_touch,
  output logic            btn_b_touch
);
  logic tog_reg;
  // Half-scale stream flips on each tick so any even ratio gives exactly half ones
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) tog_reg <= 1'b0;
    else if (mod_sample) tog_reg <= !tog_reg;
  end
  // Positive routing reads full scale, negative reads empty
  always_comb begin
    case (afe_cfg.route[1:0])
      CCS_ROUTE_POS: mod_bit = 1'b1;
      CCS_ROUTE_NEG: mod_bit = 1'b0;
      default:       mod_bit = tog_reg;
    endcase
  end
  assign btn_a_touch = press[0];
  assign btn_b_touch = press[1];
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the conversion sequencer.
// Assumes the electrode model feeds the modulator stream and touches.
`timescale 1ns/1ps
module tb_top
  import ccs_pkg::*;
;
  typedef struct packed {logic [9:0] a; logic [15:0] d;} ccs_row_s;
  ccs_row_s    rows [4] = '{'{10'h00B, 16'hFFFF}, '{10'h0E0, 16'h8000},
                            '{10'h0E1, 16'hFFFF}, '{10'h3FF, 16'h0000}};
  logic        ref_clk, rst_n, reg_rd, reg_wr, mod_bit, mod_sample, converting;
  logic        btn_a_touch, btn_b_touch, btn_a_active, btn_b_active, ff_push;
  logic [1:0]  press;
  logic [3:0]  stage_idx;
  logic [9:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  ccs_afe_s    afe_cfg;
  int          error_cnt, total_checks, t, n, push_cnt;

  ccs_sequencer #(.LP_STEP_CYC(100)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .mod_bit(mod_bit), .btn_a_touch(btn_a_touch),
    .btn_b_touch(btn_b_touch), .afe_cfg(afe_cfg), .mod_sample(mod_sample),
    .stage_idx(stage_idx), .converting(converting), .ff_push(ff_push),
    .btn_a_active(btn_a_active), .btn_b_active(btn_b_active));
  ccs_electrodes i_elec (.ref_clk(ref_clk), .rst_n(rst_n), .afe_cfg(afe_cfg),
    .mod_sample(mod_sample), .press(press), .mod_bit(mod_bit),
    .btn_a_touch(btn_a_touch), .btn_b_touch(btn_b_touch));
  //////////////////////////////////////////////////
  // Clock and watchdog; the run needs about 80,000 cycles
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #950_000;
    error_cnt++;
    complete_run;
  end
  // Fast FIFO pushes seen so far
  always @(posedge ref_clk) begin
    if (ff_push === 1'b1) push_cnt++;
  end
  //////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes drop for a full cycle so back-to-back calls never retouch them in one step
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge ref_clk) #1 reg_wr = 1'b0;
    @(posedge ref_clk) #1;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] v);
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk) #1 reg_rd = 1'b0;
    @(posedge ref_clk) #1 v = reg_rdata;
  endtask
  // Counts modulator ticks until the wanted stage shows, bounded
  task automatic wait_stage(input logic [3:0] s, output int k);
    k = 0;
    for (n = 0; n < 30000 && stage_idx !== s; n++) begin
      @(posedge ref_clk) #1;
      if (mod_sample === 1'b1) k++;
    end
  endtask
  //////////////////////////////////////////////////
  initial begin
    {reg_rd, reg_wr, reg_addr, reg_wdata, rst_n} = '0;
    press = 2'b11;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    @(posedge ref_clk) #1;
    wr(10'h000, 16'h0001);
    repeat (3) @(posedge ref_clk) #1;
    check(converting, 1'b0);
    wr(10'h080, 16'h3FFF);
    wr(10'h081, 16'h3FFF);
    wr(10'h088, 16'h3FFE);
    wr(10'h089, 16'h3FFF);
    wr(10'h08A, 16'h0A85);
    wr(10'h001, 16'h0011);
    wr(10'h000, 16'h0300);
    wait_stage(4'h1, t);
    check(t, 64);
    repeat (2) @(posedge ref_clk) #1;
    check(afe_cfg.route, 28'hFFFFFFE);
    check({afe_cfg.pos_off, afe_cfg.neg_off, afe_cfg.pos_to_neg}, {7'h05, 7'h0A, 1'b1});
    check({btn_a_active, btn_b_active}, 2'b00);
    rd(10'h00B, d);
    check(d, 16'h8000);
    press = 2'b01;
    wait_stage(4'h0, t);
    check(t, 64);
    check(converting, 1'b1);
    repeat (2) @(posedge ref_clk) #1;
    check({btn_a_active, btn_b_active}, 2'b10);
    check(push_cnt, 1);
    wr(10'h00B, 16'h1234);
    for (int i = 0; i < 4; i++) begin
      rd(rows[i].a, d);
      check(d, rows[i].d);
    end
    // Low power, delay code 01: 200 cycles of sleep at the shortened step
    wr(10'h001, 16'h0000);
    wr(10'h000, 16'h0206);
    for (t = 0; t < 40000 && converting === 1'b1; t++) @(posedge ref_clk) #1;
    for (t = 0; t < 1000 && converting === 1'b0; t++) @(posedge ref_clk) #1;
    check(t >= 200 && t <= 203, 1'b1);
    check(stage_idx, 4'h0);
    wr(10'h000, 16'h0001);
    repeat (3) @(posedge ref_clk) #1;
    check(converting, 1'b0);
    check(push_cnt, 2);
    complete_run;
  end
endmodule
